// File: shared/lcdcmd_pkg.sv
// constants for the lcd command decoder: opcodes, field widths, reset values
package lcdcmd_pkg;
    localparam int PAGE_W   = 5;     // page pointer width (21 pages)
    localparam int COL_W    = 8;     // column pointer width
    localparam int MEM_AW   = PAGE_W + COL_W;
    localparam int PAGES    = 21;
    localparam int COLS     = 256;

    // single-byte opcodes with a setting in bit 0 (bit 0 cleared here)
    localparam logic [7:0] OP_DISP_ONOFF  = 8'hAE;
    localparam logic [7:0] OP_DISP_REV    = 8'hA6;
    localparam logic [7:0] OP_ALL_ON      = 8'hA4;
    localparam logic [7:0] OP_ROW_DIR     = 8'hC4;
    localparam logic [7:0] OP_IN_DIR      = 8'h84;
    localparam logic [7:0] OP_COL_DIR     = 8'hA0;
    localparam logic [7:0] OP_NINV_ONOFF  = 8'hE4;
    localparam logic [7:0] OP_OSC_ONOFF   = 8'hAA;
    localparam logic [7:0] OP_DISCHARGE   = 8'hEA;
    localparam logic [7:0] OP_PWR_SAVE    = 8'hA8;
    localparam logic [7:0] OP_TSENSE      = 8'h28;
    // plain opcodes
    localparam logic [7:0] OP_START_LINE  = 8'h8A;
    localparam logic [7:0] OP_PAGE_ADDR   = 8'hB1;
    localparam logic [7:0] OP_COL_ADDR    = 8'h13;
    localparam logic [7:0] OP_MEM_WRITE   = 8'h1D;
    localparam logic [7:0] OP_MEM_READ    = 8'h1C;
    localparam logic [7:0] OP_NINV_COUNT  = 8'h36;
    localparam logic [7:0] OP_OSC_FREQ    = 8'h5F;
    localparam logic [7:0] OP_BIAS        = 8'hA2;
    localparam logic [7:0] OP_VOLUME      = 8'h81;
    localparam logic [7:0] OP_GRADIENT    = 8'h4E;
    localparam logic [7:0] OP_STATUS_RD   = 8'h8E;
    localparam logic [7:0] OP_DRIVE_METH  = 8'hE7;
    localparam logic [7:0] OP_RMW         = 8'hE0;
    localparam logic [7:0] OP_RMW_END     = 8'hEE;

    // reset values
    localparam logic [6:0] VOLUME_RST     = 7'h00;
    localparam logic [1:0] BIAS_RST       = 2'h0;
    localparam logic [2:0] GRAD_RST       = 3'h0;
    localparam logic [1:0] DRIVE_RST      = 2'h1;  // {overlap, dispersion}
    localparam logic [3:0] OSC_FREQ_RST   = 4'h0;
    localparam logic [4:0] NINV_CNT_RST   = 5'h00;
    // parameter field position and widths
    localparam int DRIVE_LSB   = 3;
    localparam int OSC_FREQ_W  = 4;
    localparam int NINV_W      = 5;

    // what the next data-select write means
    typedef enum logic [2:0] {
        LCDCMD_P_NONE, LCDCMD_P_START, LCDCMD_P_PAGE, LCDCMD_P_COL,
        LCDCMD_P_NINV, LCDCMD_P_OSC, LCDCMD_P_BIAS, LCDCMD_P_MISC
    } lcdcmd_param_e;
endpackage

// File: logic/lcdcmd_mem.sv
// display memory: one byte per page and column, registered read data
`timescale 1ns/100ps
module lcdcmd_mem
    import lcdcmd_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              wr_en,
    input  wire logic [MEM_AW-1:0] addr,
    input  wire logic [7:0]        wr_data,
    output logic      [7:0]        rd_data
);
    logic [7:0] store [0:(1<<MEM_AW)-1];

    // no reset on purpose: contents stay undefined until written
    always_ff @(posedge clock) begin
        if (wr_en) begin
            store[addr] <= wr_data;
        end
        rd_data <= store[addr];
    end
endmodule

// File: logic/lcdcmd_decoder.sv
// command decoder of the dot-matrix lcd driver
`timescale 1ns/100ps
module lcdcmd_decoder
    import lcdcmd_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              cs_n,
    input  wire logic              command_data_select,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [7:0]        data_in,
    output logic      [7:0]        data_out,
    output logic                   data_oe,
    output logic                   display_on,
    output logic                   display_reverse,
    output logic                   all_on,
    output logic                   row_reverse,
    output logic [7:0]             start_line,
    output logic [PAGE_W-1:0]      page_ptr,
    output logic [COL_W-1:0]       col_ptr,
    output logic                   page_direction,
    output logic                   col_reverse,
    output logic                   line_inv_on,
    output logic [NINV_W-1:0]      line_inv_count,
    output logic                   rmw_active,
    output logic                   osc_on,
    output logic [OSC_FREQ_W-1:0]  osc_freq,
    output logic [1:0]             bias_sel,
    output logic [6:0]             volume,
    output logic                   discharge,
    output logic                   power_save,
    output logic [2:0]             gradient,
    output logic                   temp_sensor_on,
    output logic                   multi_line_selection_nondisp,
    output logic                   frame_overlap_off
);
    // host strobes arrive from outside: three-stage synchronisers
    logic [2:0] rd_sync_q;
    logic [2:0] wr_sync_q;
    logic       rd_lvl_q;
    logic       wr_lvl_q;
    logic [7:0] din_q;
    logic       a0_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_sync_q <= 3'h0;
            wr_sync_q <= 3'h0;
            rd_lvl_q  <= 1'b0;
            wr_lvl_q  <= 1'b0;
        end else begin
            rd_sync_q <= {rd_sync_q[1:0], ~rd_n & ~cs_n};
            wr_sync_q <= {wr_sync_q[1:0], ~wr_n & ~cs_n};
            // level changes only once stages two and three agree
            if (rd_sync_q[1] == rd_sync_q[2]) begin
                rd_lvl_q <= rd_sync_q[2];
            end
            if (wr_sync_q[1] == wr_sync_q[2]) begin
                wr_lvl_q <= wr_sync_q[2];
            end
        end
    end

    // bus held stable across the strobe; sample on every cycle
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            din_q <= 8'h00;
            a0_q  <= 1'b0;
        end else begin
            din_q <= data_in;
            a0_q  <= command_data_select;
        end
    end

    // act at the end of a strobe, when data have long settled
    logic wr_done;
    logic rd_done;
    logic cmd_wr;
    logic dat_wr;
    logic dat_rd;
    assign wr_done = wr_lvl_q & ~wr_sync_q[1] & ~wr_sync_q[2];
    assign rd_done = rd_lvl_q & ~rd_sync_q[1] & ~rd_sync_q[2];
    assign cmd_wr  = wr_done & ~a0_q;
    assign dat_wr  = wr_done & a0_q;
    assign dat_rd  = rd_done & a0_q;

    // parameter expectation state
    lcdcmd_param_e param_q;
    logic [7:0]    pcmd_q;        // opcode owning the pending parameter
    logic          mem_wr_mode_q;
    logic          mem_rd_mode_q;
    logic          status_mode_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            param_q <= LCDCMD_P_NONE;
            pcmd_q  <= 8'h00;
        end else if (cmd_wr) begin
            pcmd_q <= din_q;
            unique case (din_q)
                OP_START_LINE: param_q <= LCDCMD_P_START;
                OP_PAGE_ADDR:  param_q <= LCDCMD_P_PAGE;
                OP_COL_ADDR:   param_q <= LCDCMD_P_COL;
                OP_NINV_COUNT: param_q <= LCDCMD_P_NINV;
                OP_OSC_FREQ:   param_q <= LCDCMD_P_OSC;
                OP_BIAS:       param_q <= LCDCMD_P_BIAS;
                OP_VOLUME, OP_GRADIENT, OP_DRIVE_METH:
                               param_q <= LCDCMD_P_MISC;
                default:       param_q <= LCDCMD_P_NONE;
            endcase
        end else if (dat_wr) begin
            param_q <= LCDCMD_P_NONE;
        end
    end

    // data-stream modes opened by write, read and status commands
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_wr_mode_q <= 1'b0;
            mem_rd_mode_q <= 1'b0;
            status_mode_q <= 1'b0;
        end else if (cmd_wr) begin
            mem_wr_mode_q <= (din_q == OP_MEM_WRITE);
            mem_rd_mode_q <= (din_q == OP_MEM_READ);
            status_mode_q <= (din_q == OP_STATUS_RD);
        end
    end

    // one-bit settings held in bit 0 of their opcodes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            display_on      <= 1'b0;
            display_reverse <= 1'b0;
            all_on          <= 1'b0;
            row_reverse     <= 1'b0;
            page_direction  <= 1'b0;
            col_reverse     <= 1'b0;
            line_inv_on     <= 1'b0;
            osc_on          <= 1'b0;
            discharge       <= 1'b0;
            power_save      <= 1'b0;
            temp_sensor_on  <= 1'b0;
        end else if (cmd_wr) begin
            unique case ({din_q[7:1], 1'b0})
                OP_DISP_ONOFF: display_on      <= din_q[0];
                OP_DISP_REV:   display_reverse <= din_q[0];
                OP_ALL_ON:     all_on          <= din_q[0];
                OP_ROW_DIR:    row_reverse     <= din_q[0];
                OP_IN_DIR:     page_direction  <= din_q[0];
                OP_COL_DIR:    col_reverse     <= din_q[0];
                OP_NINV_ONOFF: line_inv_on     <= din_q[0];
                OP_OSC_ONOFF:  osc_on          <= din_q[0];
                OP_DISCHARGE:  discharge       <= din_q[0];
                // other settings untouched, so leaving restores them
                OP_PWR_SAVE:   power_save      <= din_q[0];
                OP_TSENSE:     temp_sensor_on  <= din_q[0];
                default:       ;
            endcase
        end
    end

    // settings loaded from parameter bytes
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            start_line     <= 8'h00;
            line_inv_count <= NINV_CNT_RST;
            osc_freq       <= OSC_FREQ_RST;
            bias_sel       <= BIAS_RST;
            volume         <= VOLUME_RST;
            gradient       <= GRAD_RST;
            {frame_overlap_off, multi_line_selection_nondisp} <= DRIVE_RST;
        end else if (dat_wr) begin
            unique case (param_q)
                LCDCMD_P_START: start_line <= din_q;
                LCDCMD_P_NINV:  line_inv_count <= din_q[NINV_W-1:0];
                LCDCMD_P_OSC:   osc_freq <= din_q[OSC_FREQ_W-1:0];
                LCDCMD_P_BIAS:  bias_sel <= din_q[1:0];
                LCDCMD_P_MISC: begin
                    if (pcmd_q == OP_VOLUME) begin
                        volume <= din_q[6:0];
                    end
                    if (pcmd_q == OP_GRADIENT) begin
                        gradient <= din_q[2:0];
                    end
                    if (pcmd_q == OP_DRIVE_METH) begin
                        {frame_overlap_off, multi_line_selection_nondisp}
                            <= din_q[DRIVE_LSB+1:DRIVE_LSB];
                    end
                end
                default: ;
            endcase
        end
    end

    // memory pointer and read-modify-write bookkeeping
    logic [COL_W-1:0] saved_col_q;
    logic             mem_step;
    assign mem_step = (dat_wr & mem_wr_mode_q) | (dat_rd & mem_rd_mode_q);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            page_ptr    <= '0;
            col_ptr     <= '0;
            rmw_active  <= 1'b0;
            saved_col_q <= '0;
        end else if (cmd_wr) begin
            if (din_q == OP_RMW) begin
                rmw_active  <= 1'b1;
                saved_col_q <= col_ptr;
            end else if (din_q == OP_RMW_END && rmw_active) begin
                rmw_active <= 1'b0;
                col_ptr    <= saved_col_q;
            end
        end else if (dat_wr && param_q == LCDCMD_P_PAGE) begin
            page_ptr <= din_q[PAGE_W-1:0];
        end else if (dat_wr && param_q == LCDCMD_P_COL) begin
            col_ptr <= din_q;
        end else if (mem_step) begin
            if (rmw_active) begin
                // reads leave the column for the following write
                if (dat_wr) begin
                    col_ptr <= col_ptr + 8'h01;
                end
            end else if (page_direction) begin
                page_ptr <= (page_ptr == PAGE_W'(PAGES-1))
                            ? '0 : page_ptr + 5'h01;
            end else begin
                col_ptr <= col_ptr + 8'h01;  // wraps at 256 columns
            end
        end
    end

    // memory holds no reset path at all
    logic [7:0] mem_rd_data;
    lcdcmd_mem u_mem (
        .clock   (clock),
        .wr_en   (dat_wr & mem_wr_mode_q),
        .addr    ({page_ptr, col_ptr}),
        .wr_data (din_q),
        .rd_data (mem_rd_data)
    );

    // read data: registered, driven during a data-select read strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_out <= 8'h00;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= rd_lvl_q & a0_q;
            if (status_mode_q) begin
                data_out <= {5'h00, gradient};
            end else if (mem_rd_mode_q) begin
                data_out <= mem_rd_data;
            end else begin
                data_out <= 8'h00;
            end
        end
    end
endmodule

// File: verif/lcdcmd_host.sv
// host processor model driving the decoder strobes and data bus
`timescale 1ns/100ps
module lcdcmd_host (
    input  wire logic       clock,
    output logic            cs_n,
    output logic            command_data_select,
    output logic            rd_n,
    output logic            wr_n,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out
);
    // idle bus: nothing selected, both strobes high
    initial begin
        cs_n = 1'b1;
        command_data_select = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        data_in = 8'h00;
    end

    // one write; byte and select held well past the strobe release
    task automatic wr(input logic sel, input logic [7:0] b);
        @(posedge clock);
        cs_n <= 1'b0;
        command_data_select <= sel;
        data_in <= b;
        wr_n <= 1'b0;
        repeat (5) @(posedge clock);
        wr_n <= 1'b1;
        repeat (6) @(posedge clock);
        cs_n <= 1'b1;
        data_in <= ~b; // released bus must not keep showing the byte
        repeat (4) @(posedge clock);
    endtask

    // one read with select high; byte taken while the strobe is still low
    task automatic rd(output logic [7:0] b);
        @(posedge clock);
        cs_n <= 1'b0;
        command_data_select <= 1'b1;
        rd_n <= 1'b0;
        repeat (9) @(posedge clock);
        b = data_out;
        rd_n <= 1'b1;
        repeat (8) @(posedge clock);
        cs_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
endmodule

// File: verif/lcdcmd_decoder_props.sv
// port-level checker of the lcd command decoder
`timescale 1ns/100ps
module lcdcmd_decoder_props
    import lcdcmd_pkg::*;
(
    input wire logic             clock,
    input wire logic             reset_n,
    input wire logic             cs_n,
    input wire logic             rd_n,
    input wire logic             wr_n,
    input wire logic             data_oe,
    input wire logic             display_on,
    input wire logic             power_save,
    input wire logic             rmw_active,
    input wire logic [COL_W-1:0] col_ptr,
    input wire logic [6:0]       volume,
    input wire logic [2:0]       gradient,
    input wire logic [1:0]       bias_sel,
    input wire logic [3:0]       osc_freq,
    input wire logic             multi_line_selection_nondisp
);
    logic [COL_W-1:0] entry_col_q;
    logic             rmw_seen_q;

    // column at read-modify-write entry, for the restore check
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            entry_col_q <= '0;
            rmw_seen_q <= 1'b0;
        end else begin
            rmw_seen_q <= rmw_active;
            if (rmw_active && !rmw_seen_q) begin
                entry_col_q <= col_ptr;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // eight quiet cycles outlast the strobe synchroniser
    sequence wr_quiet; wr_n [*8]; endsequence
    sequence rd_quiet; rd_n [*8]; endsequence

    reset_vals_a: assert property (
        $rose(reset_n) |-> volume == 7'h00 && multi_line_selection_nondisp)
        else $error("volume or drive method not at reset value");
    set_hold_a: assert property (
        wr_quiet |=> $stable(volume) && $stable(gradient) && $stable(bias_sel))
        else $error("setting moved with no write strobe");
    oe_start_a: assert property (
        $rose(data_oe) |-> !rd_n && !cs_n)
        else $error("bus driven without a read strobe");
    oe_stop_a: assert property (
        rd_quiet |-> !data_oe)
        else $error("bus still driven after the read ended");
    rmw_step_a: assert property (
        rmw_active && $past(rmw_active) && $changed(col_ptr)
            |-> col_ptr == $past(col_ptr) + 8'h01)
        else $error("column moved by other than one in rmw");
    rmw_restore_a: assert property (
        $fell(rmw_active) |-> col_ptr == entry_col_q)
        else $error("column not restored at rmw end");
    save_keep_a: assert property (
        $changed(power_save) |-> $stable(display_on) && $stable(volume))
        else $error("power save altered other settings");
    one_change_a: assert property (
        $changed(volume) |-> $stable(gradient) && $stable(osc_freq))
        else $error("one parameter changed two settings");
endmodule

bind lcdcmd_decoder lcdcmd_decoder_props u_props (
    .clock(clock), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_oe(data_oe), .display_on(display_on),
    .power_save(power_save), .rmw_active(rmw_active), .col_ptr(col_ptr),
    .volume(volume), .gradient(gradient), .bias_sel(bias_sel),
    .osc_freq(osc_freq),
    .multi_line_selection_nondisp(multi_line_selection_nondisp)
);

// File: verif/lcdcmd_decoder_tb.sv
// self-checking testbench of the lcd command decoder
`timescale 1ns/100ps
module lcdcmd_decoder_tb;
    import lcdcmd_pkg::*;
    logic              clock;
    logic              reset_n;
    logic              cs_n;
    logic              sel;
    logic              rd_n;
    logic              wr_n;
    logic [7:0]        data_in;
    logic [7:0]        data_out;
    logic [7:0]        start_line;
    logic [PAGE_W-1:0] page_ptr;
    logic [COL_W-1:0]  col_ptr;
    logic [6:0]        volume;
    logic [3:0]        osc_freq;
    logic [2:0]        gradient;
    logic [NINV_W-1:0] ninv_cnt;
    logic [1:0]        bias_sel;
    wire logic [10:0]  bits; // one-bit settings gathered by index
    logic [7:0]        v;
    int                miscompares = 0;
    int                total_checks = 0;
    localparam logic [7:0] TOGGLE_OPS [8] = '{OP_DISP_ONOFF, OP_ROW_DIR,
        OP_IN_DIR, OP_NINV_ONOFF, OP_OSC_ONOFF, OP_DISCHARGE, OP_PWR_SAVE,
        OP_TSENSE};

    lcdcmd_decoder uut (.clock(clock), .reset_n(reset_n), .cs_n(cs_n),
        .command_data_select(sel), .rd_n(rd_n), .wr_n(wr_n),
        .data_in(data_in), .data_out(data_out), .data_oe(),
        .display_on(bits[0]), .display_reverse(), .all_on(),
        .row_reverse(bits[1]), .start_line(start_line),
        .page_ptr(page_ptr), .col_ptr(col_ptr), .page_direction(bits[2]),
        .col_reverse(), .line_inv_on(bits[3]), .line_inv_count(ninv_cnt),
        .rmw_active(bits[8]), .osc_on(bits[4]), .osc_freq(osc_freq),
        .bias_sel(bias_sel), .volume(volume), .discharge(bits[5]),
        .power_save(bits[6]), .gradient(gradient),
        .temp_sensor_on(bits[7]), .multi_line_selection_nondisp(bits[9]),
        .frame_overlap_off(bits[10]));
    lcdcmd_host host (.clock(clock), .cs_n(cs_n),
        .command_data_select(sel), .rd_n(rd_n), .wr_n(wr_n),
        .data_in(data_in), .data_out(data_out));

    // free-running 100 MHz clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h not %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // command byte followed by its one parameter byte
    task automatic setp(input logic [7:0] op, input logic [7:0] p);
        host.wr(1'b0, op);
        host.wr(1'b1, p);
    endtask

    task automatic t_reset;
        check(bits[7:0], 8'h00, "one-bit settings");
        check(8'(bits[10:9]), 8'h01, "drive method");
        check(8'(volume), 8'h00, "volume");
        $display("test reset done");
    endtask

    // every bit-0 command but reverse, all-on and column direction set then cleared; power save must keep display
    task automatic t_toggles;
        for (int i = 0; i < 8; i++) begin
            host.wr(1'b0, TOGGLE_OPS[i] | 8'h01);
            check(8'(bits[i]), 8'h01, "bit set");
            host.wr(1'b0, TOGGLE_OPS[i]);
            check(8'(bits[i]), 8'h00, "bit clear");
        end
        host.wr(1'b0, OP_DISP_ONOFF | 8'h01);
        host.wr(1'b0, OP_PWR_SAVE | 8'h01);
        host.wr(1'b0, OP_PWR_SAVE);
        check(8'(bits[0]), 8'h01, "display after save");
        $display("test toggles done");
    endtask

    // parameters with ignored bits set to prove the masking
    task automatic t_params;
        setp(OP_START_LINE, 8'hC3);
        check(start_line, 8'hC3, "start line");
        setp(OP_OSC_FREQ, 8'hF9);
        check(8'(osc_freq), 8'h09, "osc freq");
        setp(OP_NINV_COUNT, 8'hF3);
        check(8'(ninv_cnt), 8'h13, "line count");
        setp(OP_BIAS, 8'hFE);
        check(8'(bias_sel), 8'h02, "bias");
        setp(OP_VOLUME, 8'hFF);
        check(8'(volume), 8'h7F, "volume");
        host.wr(1'b1, 8'h44);
        check(8'(volume), 8'h7F, "stray data");
        setp(OP_GRADIENT, 8'hFD);
        check(8'(gradient), 8'h05, "gradient");
        setp(OP_DRIVE_METH, 8'h13);
        check(8'(bits[10:9]), 8'h02, "drive method");
        $display("test params done");
    endtask

    task automatic t_mem;
        setp(OP_PAGE_ADDR, 8'hE2);
        check(8'(page_ptr), 8'h02, "page");
        setp(OP_COL_ADDR, 8'hF0);
        check(col_ptr, 8'hF0, "column");
        host.wr(1'b0, OP_MEM_WRITE);
        host.wr(1'b1, 8'hA5);
        host.wr(1'b1, 8'h5A);
        check(col_ptr, 8'hF2, "column after writes");
        setp(OP_COL_ADDR, 8'hF0);
        host.wr(1'b0, OP_MEM_READ);
        host.rd(v);
        check(v, 8'hA5, "first byte");
        host.rd(v);
        check(v, 8'h5A, "second byte");
        host.wr(1'b0, OP_STATUS_RD);
        host.rd(v);
        check(v, 8'h05, "status");
        $display("test memory done");
    endtask

    task automatic t_rmw;
        setp(OP_COL_ADDR, 8'h20);
        host.wr(1'b0, OP_RMW);
        // reads and writes still need their own stream commands
        host.wr(1'b0, OP_MEM_READ);
        host.rd(v);
        check(col_ptr, 8'h20, "column after rmw read");
        host.wr(1'b0, OP_MEM_WRITE);
        host.wr(1'b1, 8'h3C);
        host.wr(1'b1, 8'hC3);
        check(col_ptr, 8'h22, "column after rmw writes");
        host.wr(1'b0, OP_RMW_END);
        check(col_ptr, 8'h20, "column after end");
        check(8'(bits[8]), 8'h00, "rmw left");
        $display("test rmw done");
    endtask

    // a hang costs 20000 cycles, about twenty times the 940 or so cycles the run needs
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        $display("mismatch at %0t: watchdog expired", $time);
        test_done();
    end

    initial begin
        reset_n = 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_toggles();
        t_params();
        t_mem();
        t_rmw();
        test_done();
    end
endmodule
